// ### wdt_cnt_if.sv
// carrier between watchdog control and its counter
`timescale 1ns/1ns
interface wdt_cnt_if;
   import wdt_pkg::*;
   logic          restart;
   wdt_count_type limit;
   wdt_count_type warn_at;
   wdt_count_type count;
   logic          hit_warn;
   logic          hit_timeout;
   modport ctrl (output restart, output limit, output warn_at, input count, input hit_warn, input hit_timeout);
   modport cnt  (input restart, input limit, input warn_at, output count, output hit_warn, output hit_timeout);
endinterface : wdt_cnt_if

// ### wdt_counter.sv
// free-running watchdog counter with warning and timeout compares
`timescale 1ns/1ns
module wdt_counter (
   input  wire logic clock,
   input  wire logic rst,
   wdt_cnt_if.cnt    cb
);
   import wdt_pkg::*;

   wdt_count_type count_r;
   wdt_count_type count_nxt;
   logic          warn_hit_r;
   logic          tout_hit_r;

   always_comb begin
      if (cb.restart || tout_hit_r) begin
         count_nxt = '0;
      end else begin
         count_nxt = count_r + wdt_count_type'(1);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count_r <= '0;
      end else begin
         count_r <= count_nxt;
      end
   end

   // single-cycle pulses; >= on timeout guards against a shortened interval
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         warn_hit_r <= 1'b0;
         tout_hit_r <= 1'b0;
      end else begin
         warn_hit_r <= !cb.restart && !tout_hit_r && (count_r == cb.warn_at);
         tout_hit_r <= !cb.restart && !tout_hit_r && (count_r >= cb.limit - wdt_count_type'(1));
      end
   end

   assign cb.count       = count_r;
   assign cb.hit_warn    = warn_hit_r;
   assign cb.hit_timeout = tout_hit_r;
endmodule : wdt_counter

// ### wdt_pkg.sv
// shared constants for the watchdog timeout unit
package wdt_pkg;
   localparam int unsigned WDT_CNT_W        = 22;
   localparam int unsigned WDT_CTRL_W       = 4;
   // control word field positions
   localparam int unsigned WDT_SEL_LSB      = 0;
   localparam int unsigned WDT_SEL_W        = 2;
   localparam int unsigned WDT_INTEN_BIT    = 2;
   localparam int unsigned WDT_RESTART_BIT  = 3;
   // status word field positions
   localparam int unsigned WDT_ST_INTF_BIT  = 2;
   localparam int unsigned WDT_ST_RSTF_BIT  = 3;
   localparam int unsigned WDT_STAT_W       = 4;
   // reset values
   localparam logic [1:0] WDT_SEL_RST       = 2'h0;
   localparam logic       WDT_INTEN_RST     = 1'b0;
   // timing counts in system clocks
   localparam int unsigned WDT_INTERVAL0    = 4096;
   localparam int unsigned WDT_INTERVAL1    = 32768;
   localparam int unsigned WDT_INTERVAL2    = 262144;
   localparam int unsigned WDT_INTERVAL3    = 2097152;
   localparam int unsigned WDT_WARN_LEAD    = 512;
   localparam int unsigned WDT_RST_PULSE    = 1;
   typedef logic [WDT_CNT_W-1:0] wdt_count_type;
endpackage : wdt_pkg

// ### wdt_timeout_unit.sv
// watchdog timeout unit: control word, early warning and system reset
//
// How it works
// - the counter runs freely from zero and any restart puts it back, so regular restarts keep it short of timeout.
// - if the counter reaches the timeout, a system reset is pulsed, preceded by the warning interrupt only when enabled.
// - software chooses one of four timeout intervals, from 2^12 up to 2^21 system clocks.
// - with the interrupt enabled the warning rises exactly 512 clocks before the reset pulse.
// - interval select, interrupt enable and restart are bits of the one watchdog control word.
`timescale 1ns/1ns
module wdt_timeout_unit #(
   parameter int unsigned INTERVAL0 = wdt_pkg::WDT_INTERVAL0,
   parameter int unsigned INTERVAL1 = wdt_pkg::WDT_INTERVAL1,
   parameter int unsigned INTERVAL2 = wdt_pkg::WDT_INTERVAL2,
   parameter int unsigned INTERVAL3 = wdt_pkg::WDT_INTERVAL3,
   parameter int unsigned WARN_LEAD = wdt_pkg::WDT_WARN_LEAD
) (
   input  wire logic                          clock,
   input  wire logic                          rst,
   input  wire logic                          ctrl_write,
   input  wire logic [wdt_pkg::WDT_CTRL_W-1:0] ctrl_wdata,
   output logic      [wdt_pkg::WDT_STAT_W-1:0] ctrl_rdata,
   output logic                               wdt_irq,
   output logic                               sys_reset_req
);
   import wdt_pkg::*;

   wdt_cnt_if cb ();

   // visible phase of the watchdog
   // one-hot codes make a disturbed state register fall back to run
   typedef enum logic [2:0] {
      WDT_PH_RUN  = 3'b001,
      WDT_PH_WARN = 3'b010,
      WDT_PH_FIRE = 3'b100
   } wdt_phase_type;

   wdt_phase_type        phase_r;
   wdt_phase_type        phase_nxt;
   logic [WDT_SEL_W-1:0] sel_r;
   logic                 inten_r;
   logic                 rstf_r;
   logic [WDT_SEL_W-1:0] stat_sel_r;
   logic                 stat_warn_r;
   logic                 stat_rstf_r;
   logic                 restart;
   logic                 warn_take;
   logic                 fire_take;
   logic                 rstf_set;
   logic                 rstf_clr;
   logic                 in_warn;
   wdt_count_type        limit;
   wdt_count_type        warn_at;

   // timeout length in clocks for a select code
   // codes 0..3 give rising powers of two
   function automatic wdt_count_type limit_of(input logic [WDT_SEL_W-1:0] sel);
      unique case (sel)
         2'h0: limit_of = wdt_count_type'(INTERVAL0);
         2'h1: limit_of = wdt_count_type'(INTERVAL1);
         2'h2: limit_of = wdt_count_type'(INTERVAL2);
         2'h3: limit_of = wdt_count_type'(INTERVAL3);
      endcase
   endfunction

   // count value one edge ahead of the warning pulse; the phase register adds one more edge,
   // so the warning level rises exactly WARN_LEAD clocks before the reset pulse
   function automatic wdt_count_type warn_of(input wdt_count_type lim);
      warn_of = lim - wdt_count_type'(WARN_LEAD) - wdt_count_type'(2);
   endfunction

   // status word as software reads it
   // unused bits read as zero
   function automatic logic [WDT_STAT_W-1:0] status_of(
      input logic [WDT_SEL_W-1:0] sel,
      input logic                 warn,
      input logic                 rstf
   );
      status_of                           = '0;
      status_of[WDT_SEL_LSB +: WDT_SEL_W] = sel;
      status_of[WDT_ST_INTF_BIT]          = warn;
      status_of[WDT_ST_RSTF_BIT]          = rstf;
   endfunction

   // watchdog_control_reg: interval select
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sel_r <= WDT_SEL_RST;
      end else if (ctrl_write) begin
         sel_r <= ctrl_wdata[WDT_SEL_LSB +: WDT_SEL_W];
      end
   end

   // watchdog_control_reg: interrupt enable
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         inten_r <= WDT_INTEN_RST;
      end else if (ctrl_write) begin
         inten_r <= ctrl_wdata[WDT_INTEN_BIT];
      end
   end

   // restart bit acts as a strobe, never stored
   // a new select alone does not restart the count
   assign restart = ctrl_write && ctrl_wdata[WDT_RESTART_BIT];

   // one interval decode feeds both compares
   assign limit   = limit_of(sel_r);
   assign warn_at = warn_of(limit);

   // counter side of the carrier
   assign cb.restart = restart;
   assign cb.limit   = limit;
   assign cb.warn_at = warn_at;

   // counter reloads on its own after a timeout
   wdt_counter wdt_counter_inst (
      .clock (clock),
      .rst   (rst),
      .cb    (cb.cnt)
   );

   // a warning only counts while the interrupt option is on
   assign warn_take = cb.hit_warn && inten_r;
   assign fire_take = cb.hit_timeout;

   // next phase; a new warning wins over a restart clearing the old one
   // the warning level ends with the edge that follows the reset pulse
   always_comb begin
      phase_nxt = phase_r;
      unique case (phase_r)
         WDT_PH_RUN: begin
            // counting, nothing shown
            if (warn_take) begin
               phase_nxt = WDT_PH_WARN;
            end else if (fire_take) begin
               phase_nxt = WDT_PH_FIRE;
            end
         end
         WDT_PH_WARN: begin
            // warning shown until restart or reset pulse
            if (warn_take) begin
               phase_nxt = WDT_PH_WARN;
            end else if (fire_take) begin
               phase_nxt = WDT_PH_FIRE;
            end else if (restart) begin
               phase_nxt = WDT_PH_RUN;
            end
         end
         WDT_PH_FIRE: begin
            // cycle after the reset pulse
            if (warn_take) begin
               phase_nxt = WDT_PH_WARN;
            end else begin
               phase_nxt = WDT_PH_RUN;
            end
         end
         default: begin
            phase_nxt = WDT_PH_RUN;
         end
      endcase
   end

   // phase register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         phase_r <= WDT_PH_RUN;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   assign in_warn = (phase_r == WDT_PH_WARN);

   // sticky record that a watchdog reset was issued, cleared by a restart; the set wins
   assign rstf_set = fire_take;
   assign rstf_clr = restart;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rstf_r <= 1'b0;
      end else if (rstf_set) begin
         rstf_r <= 1'b1;
      end else if (rstf_clr) begin
         rstf_r <= 1'b0;
      end
   end

   // registered status: select shown
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stat_sel_r <= '0;
      end else begin
         stat_sel_r <= sel_r;
      end
   end

   // registered status: warning level shown
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stat_warn_r <= 1'b0;
      end else begin
         stat_warn_r <= in_warn;
      end
   end

   // registered status: watchdog reset record shown
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stat_rstf_r <= 1'b0;
      end else begin
         stat_rstf_r <= rstf_r;
      end
   end

   // outputs
   assign ctrl_rdata    = status_of(stat_sel_r, stat_warn_r, stat_rstf_r);
   assign wdt_irq       = in_warn;
   assign sys_reset_req = cb.hit_timeout;
endmodule : wdt_timeout_unit

// ### wdt_timeout_unit_props.sv
// property checker for the watchdog timeout unit
`timescale 1ns/1ns
module wdt_props #(
   parameter int unsigned WARN_LEAD = 8
) (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       ctrl_write,
   input wire logic [3:0] ctrl_wdata,
   input wire logic [3:0] ctrl_rdata,
   input wire logic       wdt_irq,
   input wire logic       sys_reset_req
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire kick = ctrl_write && ctrl_wdata[3];
   property p_lead;
      disable iff (rst || kick) $rose(wdt_irq) && !$past(kick) |-> ##WARN_LEAD sys_reset_req;
   endproperty
   a_lead: assert property (p_lead) else $error("reset not at lead after warning");
   property p_fall; sys_reset_req |=> !wdt_irq; endproperty
   a_fall: assert property (p_fall) else $error("warning high with reset");
   property p_gap; sys_reset_req |=> !sys_reset_req [*8]; endproperty
   a_gap: assert property (p_gap) else $error("reset pulses too close");
   property p_kick; kick |=> !sys_reset_req [*8]; endproperty
   a_kick: assert property (p_kick) else $error("reset soon after restart");
   property p_sel; ctrl_write |-> ##2 ctrl_rdata[1:0] == $past(ctrl_wdata[1:0], 2); endproperty
   a_sel: assert property (p_sel) else $error("select not stored");
   property p_clr; kick && !sys_reset_req |-> ##2 !ctrl_rdata[3]; endproperty
   a_clr: assert property (p_clr) else $error("reset flag not cleared");
endmodule // wdt_props

// ### wdt_timeout_unit_test.sv
// self-checking bench for the watchdog timeout unit
`timescale 1ns/1ns
module wdt_timeout_unit_test;
   localparam int L[4] = '{64, 128, 256, 512};
   logic       clock = 0, rst = 1, ctrl_write = 0;
   logic [3:0] ctrl_wdata = 4'h0;
   logic [3:0] ctrl_rdata;
   logic       wdt_irq, sys_reset_req;
   int         error_cnt = 0, total_checks = 0, cyc = 0;
   wdt_timeout_unit #(.INTERVAL0(64), .INTERVAL1(128), .INTERVAL2(256), .INTERVAL3(512), .WARN_LEAD(8))
      wdt_timeout_unit_inst (.clock, .rst, .ctrl_write, .ctrl_wdata, .ctrl_rdata, .wdt_irq, .sys_reset_req);
   initial forever #25 clock = ~clock;
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         error_cnt++;
         conclude();
      end
   end
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic wr(logic [3:0] w);
      ctrl_wdata = w;
      ctrl_write = 1;
      @(negedge clock);
      ctrl_write = 0;
   endtask
   task automatic t_sel(logic [1:0] s);
      int n, irq_n;
      irq_n = 0;
      wr({1'b1, s != 2'h1, s});
      for (n = 0; n < 600 && !sys_reset_req; n++) begin
         if (wdt_irq && irq_n == 0) irq_n = n;
         @(negedge clock);
      end
      chk("timeout", L[s], n);
      chk("warning", (s == 2'h1) ? 0 : L[s] - 8, irq_n);
      repeat (2) @(negedge clock);
      chk("status", {2'h2, s}, ctrl_rdata);
      $display("test sel %0d done", s);
   endtask
   task automatic t_kick();
      int n, hits;
      hits = 0;
      for (n = 0; n < 250; n++) begin
         if (n % 50 == 0) wr(4'hc);
         else @(negedge clock);
         hits += wdt_irq | sys_reset_req;
      end
      chk("alarms while kicked", 0, hits);
      chk("flag cleared", 0, ctrl_rdata[3]);
      $display("test kick done");
   endtask
   initial begin
      repeat (3) @(negedge clock);
      rst = 0;
      chk("reset outputs", 0, {ctrl_rdata, wdt_irq, sys_reset_req});
      for (int i = 0; i < 4; i++) t_sel(2'(i));
      t_kick();
      conclude();
   end
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
endmodule // wdt_timeout_unit_test
bind wdt_timeout_unit wdt_props #(.WARN_LEAD(WARN_LEAD)) wdt_props_inst (.clock, .rst, .ctrl_write, .ctrl_wdata,
   .ctrl_rdata, .wdt_irq, .sys_reset_req);
